//--- verilog/pbr_pkg.sv
package pbr_pkg;
    // ------------------------------------------------------------
    // Variant selection
    // ------------------------------------------------------------
    localparam logic [1:0] PBR_VAR_DUAL_HOLD = 2'h0;  // Two buttons, hold until release
    localparam logic [1:0] PBR_VAR_DUAL_PULSE = 2'h1; // Two buttons, fixed pulse
    localparam logic [1:0] PBR_VAR_SINGLE_PULSE = 2'h2; // One button, fixed pulse

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint PBR_CLK_HZ = 40000000;
    localparam longint PBR_DELAY_HI_MS = 7500; // Hold delay, select high
    localparam longint PBR_DELAY_LO_MS = 0;    // Hold delay, select low
    localparam longint PBR_PULSE_MS = 400;     // Fixed reset pulse width
    localparam int PBR_DELAY_HI_CYC = int'((PBR_DELAY_HI_MS * PBR_CLK_HZ) / 1000);
    localparam int PBR_DELAY_LO_CYC = int'((PBR_DELAY_LO_MS * PBR_CLK_HZ) / 1000);
    localparam int PBR_PULSE_CYC = int'((PBR_PULSE_MS * PBR_CLK_HZ) / 1000);
    localparam int PBR_CNT_W = 32;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PBR_IDLE = 4'h1,
        PBR_TIMING = 4'h2,
        PBR_RESET = 4'h4,
        PBR_WAIT_REL = 4'h8
    } pbr_state_e;
endpackage : pbr_pkg

//--- verilog/pbr_sync.sv
`timescale 1ns/1ps
module pbr_sync
    import pbr_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Two-stage synchroniser, resets to released (high)
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : pbr_sync

//--- verilog/pbr_timer.sv
`timescale 1ns/1ps
module pbr_timer
    import pbr_pkg::*;
#(
    parameter logic [1:0] VARIANT = PBR_VAR_DUAL_PULSE,
    parameter int DELAY_HI_CYC = PBR_DELAY_HI_CYC,
    parameter int DELAY_LO_CYC = PBR_DELAY_LO_CYC,
    parameter int PULSE_CYC = PBR_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic button_in_a_n,
    input wire logic button_in_b_n,
    input wire logic delay_select,
    input wire logic test_strap_pin,
    output logic reset_out_n_o,
    output logic reset_out_n_oe,
    output logic reset_active
);
    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [2:0] sync_w;
    logic a_n;
    logic b_n;
    logic sel;
    logic pressed;

    pbr_sync #(.WIDTH(3)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in({delay_select, button_in_b_n, button_in_a_n}),
        .sync_out(sync_w)
    );

    assign a_n = sync_w[0];
    assign b_n = sync_w[1];
    assign sel = sync_w[2];

    // Press condition per variant; the strap pin has no function here
    always_comb begin
        if (VARIANT == PBR_VAR_SINGLE_PULSE) begin
            pressed = !a_n;
        end else begin
            pressed = !a_n && !b_n;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    pbr_state_e state_q, state_d;
    logic [PBR_CNT_W-1:0] cnt_q, cnt_d;
    logic [PBR_CNT_W-1:0] delay_cyc;
    logic rst_low_q, rst_low_d;

    // Selected hold delay from the synchronised delay_select level
    assign delay_cyc = sel ? PBR_CNT_W'(DELAY_HI_CYC) : PBR_CNT_W'(DELAY_LO_CYC);

    // Next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        rst_low_d = 1'b0;
        case (state_q)
            PBR_IDLE: begin
                cnt_d = '0;
                if (pressed) begin
                    state_d = PBR_TIMING;
                end
            end
            PBR_TIMING: begin
                if (!pressed) begin
                    state_d = PBR_IDLE;
                    cnt_d = '0;
                end else if (cnt_q >= delay_cyc) begin
                    state_d = PBR_RESET;
                    cnt_d = '0;
                    rst_low_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PBR_RESET: begin
                rst_low_d = 1'b1;
                if (VARIANT == PBR_VAR_DUAL_HOLD) begin
                    if (a_n || b_n) begin
                        state_d = PBR_IDLE;
                        rst_low_d = 1'b0;
                    end
                end else if (cnt_q >= PBR_CNT_W'(PULSE_CYC - 1)) begin
                    state_d = PBR_WAIT_REL;
                    cnt_d = '0;
                    rst_low_d = 1'b0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PBR_WAIT_REL: begin
                cnt_d = '0;
                if (!pressed) begin
                    state_d = PBR_IDLE;
                end
            end
            default: begin
                state_d = PBR_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= PBR_IDLE;
            cnt_q <= '0;
            rst_low_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rst_low_q <= rst_low_d;
        end
    end

    // ------------------------------------------------------------
    // Open-drain output
    // ------------------------------------------------------------
    logic oe_q;
    // Pull-down enable follows the registered reset decision
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= rst_low_d;
        end
    end

    assign reset_out_n_o = 1'b0;
    assign reset_out_n_oe = oe_q;
    assign reset_active = rst_low_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_never_high;
        @(posedge mclk) disable iff (!rst_b) reset_out_n_oe |-> !reset_out_n_o;
    endproperty
    a_never_high: assert property (p_never_high) else $error("reset driven high");

    property p_oe_matches;
        @(posedge mclk) disable iff (!rst_b) reset_out_n_oe == reset_active;
    endproperty
    a_oe_matches: assert property (p_oe_matches) else $error("enable and state differ");

    property p_assert_needs_press;
        @(posedge mclk) disable iff (!rst_b) $rose(reset_active) |-> $past(state_q) == PBR_TIMING;
    endproperty
    a_assert_needs_press: assert property (p_assert_needs_press) else $error("reset without timing");

    property p_dual_both;
        @(posedge mclk) disable iff (!rst_b)
            (VARIANT != PBR_VAR_SINGLE_PULSE) && $rose(reset_active) |-> !$past(a_n) && !$past(b_n);
    endproperty
    a_dual_both: assert property (p_dual_both) else $error("dual reset without both");

    property p_single_a;
        @(posedge mclk) disable iff (!rst_b)
            (VARIANT == PBR_VAR_SINGLE_PULSE) && $rose(reset_active) |-> !$past(a_n);
    endproperty
    a_single_a: assert property (p_single_a) else $error("single reset without A");

    property p_release_clears;
        @(posedge mclk) disable iff (!rst_b) (state_q == PBR_TIMING) && !pressed |=> cnt_q == '0;
    endproperty
    a_release_clears: assert property (p_release_clears) else $error("timer not cleared");

    property p_hold_release;
        @(posedge mclk) disable iff (!rst_b)
            (VARIANT == PBR_VAR_DUAL_HOLD) && reset_active && (a_n || b_n) |=> !reset_active;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold reset not released");

    property p_pulse_end;
        @(posedge mclk) disable iff (!rst_b)
            (VARIANT != PBR_VAR_DUAL_HOLD) && $fell(reset_active) |-> $past(cnt_q) == PBR_CNT_W'(PULSE_CYC - 1);
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse width wrong");

    property p_rearm;
        @(posedge mclk) disable iff (!rst_b) (state_q == PBR_WAIT_REL) && pressed |=> !reset_active;
    endproperty
    a_rearm: assert property (p_rearm) else $error("pulse retriggered");

    property p_delay_met;
        @(posedge mclk) disable iff (!rst_b)
            $rose(reset_active) |-> $past(cnt_q) >= $past(delay_cyc);
    endproperty
    a_delay_met: assert property (p_delay_met) else $error("reset before hold delay");

    property p_pulse_holds;
        @(posedge mclk) disable iff (!rst_b)
            (VARIANT != PBR_VAR_DUAL_HOLD) && reset_active && (cnt_q < PBR_CNT_W'(PULSE_CYC - 1)) |=> reset_active;
    endproperty
    a_pulse_holds: assert property (p_pulse_holds) else $error("pulse ended early");

    property p_reset_in_state;
        @(posedge mclk) disable iff (!rst_b) reset_active == (state_q == PBR_RESET);
    endproperty
    a_reset_in_state: assert property (p_reset_in_state) else $error("reset outside reset state");

    c_timing: cover property (@(posedge mclk) disable iff (!rst_b) state_q == PBR_TIMING && !pressed);
    c_reset: cover property (@(posedge mclk) disable iff (!rst_b) $rose(reset_active));
    c_release: cover property (@(posedge mclk) disable iff (!rst_b) $fell(reset_active));
    c_rearm: cover property (@(posedge mclk) disable iff (!rst_b) state_q == PBR_WAIT_REL && !pressed);
endmodule : pbr_timer

//--- test/pbr_net_model.sv
`timescale 1ns/1ps
module pbr_net_model (
    input wire logic drv_a_oe,
    input wire logic drv_a_o,
    input wire logic drv_b_oe,
    input wire logic drv_b_o,
    output logic reset_net_n
);
    // ------------------------------------------------------------
    // Wired reset net with pull-up
    // ------------------------------------------------------------
    // Only an enabled source driving low pulls the net down
    assign reset_net_n = !((drv_a_oe && !drv_a_o) || (drv_b_oe && !drv_b_o));
endmodule : pbr_net_model

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pbr_pkg::*;
    localparam int DHI = 20;
    localparam int PW = 10;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic btn_a_n = 1'b1;
    logic btn_b_n = 1'b1;
    logic dsel = 1'b1;
    logic [2:0] oe;
    logic [2:0] od;
    logic [2:0] act;
    logic net_n;
    int failures = 0;
    int checks_done = 0;
    int n;
    int w;
    // ------------------------------------------------------------
    // One instance per variant: hold dual, pulse dual, pulse single
    // ------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_var
        pbr_timer #(.VARIANT(2'(i)), .DELAY_HI_CYC(DHI), .DELAY_LO_CYC(0), .PULSE_CYC(PW)) DUT (
            .mclk(mclk), .rst_b(rst_b), .button_in_a_n(btn_a_n), .button_in_b_n(btn_b_n),
            .delay_select(dsel), .test_strap_pin(1'b0),
            .reset_out_n_o(od[i]), .reset_out_n_oe(oe[i]), .reset_active(act[i]));
    end
    pbr_net_model net (.drv_a_oe(oe[0]), .drv_a_o(od[0]), .drv_b_oe(oe[1]), .drv_b_o(od[1]),
        .reset_net_n(net_n));
    // Clock
    initial forever #12.5 mclk = ~mclk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task press(input logic a, input logic b);
        @(posedge mclk);
        btn_a_n <= a;
        btn_b_n <= b;
    endtask : press
    // Cycles until the output pulls low, then how long it stays low
    task measure(input int idx, output int rise, output int width);
        rise = 0;
        width = 0;
        while (oe[idx] !== 1'b1 && rise < 40) begin
            @(negedge mclk);
            rise++;
        end
        while (oe[idx] === 1'b1 && width < 40) begin
            @(negedge mclk);
            width++;
        end
    endtask : measure
    task end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_short;
        press(1'b0, 1'b0);
        repeat (15) @(negedge mclk);
        check(oe, 3'h0);
        check(act, 3'h0);
        press(1'b1, 1'b1);
        repeat (4) @(posedge mclk);
        press(1'b0, 1'b0);
        repeat (15) @(negedge mclk);
        check(oe, 3'h0);
        press(1'b1, 1'b1);
        repeat (6) @(posedge mclk);
    endtask : t_short
    task t_single;
        press(1'b0, 1'b1);
        measure(2, n, w);
        check(n >= DHI && n < 40, 1'b1);
        check(w, PW);
        check(oe[1:0], 2'h0);
        press(1'b1, 1'b1);
        repeat (6) @(posedge mclk);
    endtask : t_single
    task t_both;
        press(1'b0, 1'b0);
        measure(1, n, w);
        check(n >= DHI && n < 40, 1'b1);
        check(w, PW);
        check(oe[0], 1'b1);
        check(act, 3'h1);
        check(net_n, 1'b0);
        repeat (30) @(negedge mclk);
        check(oe[1], 1'b0);
        check(oe[0], 1'b1);
        press(1'b1, 1'b0);
        repeat (5) @(negedge mclk);
        check(oe[0], 1'b0);
        check(act, 3'h0);
        check(net_n, 1'b1);
        check(od, 3'h0);
        press(1'b1, 1'b1);
        repeat (6) @(posedge mclk);
    endtask : t_both
    task t_zero;
        @(posedge mclk);
        dsel <= 1'b0;
        repeat (4) @(posedge mclk);
        press(1'b0, 1'b0);
        measure(1, n, w);
        check(n < 8, 1'b1);
        check(w, PW);
        press(1'b1, 1'b1);
        repeat (6) @(posedge mclk);
        dsel <= 1'b1;
    endtask : t_zero
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_short();
        t_single();
        t_both();
        t_zero();
        end_sim();
    end
    // Watchdog
    initial begin
        #(25 * 2000);
        failures++;
        end_sim();
    end
endmodule : testbench
